// File: logic/io_cell_defines.svh
`ifndef IO_CELL_DEFINES_SVH
`define IO_CELL_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses, one aligned word each)
`define CFG_OFFSET 8'h00
`define CTRL_OFFSET 8'h04
`define STATUS_OFFSET 8'h08

// ==========================================================================
// Reset values
`define CFG_RESET 8'h00
`define RDATA_RESET 32'h0000_0000

// ==========================================================================
// Field positions
`define CTRL_STARTUP_BIT 0
`define ST_IN_Q_BIT 0
`define ST_OUT_Q_BIT 1
`define ST_PAD_LEVEL_BIT 2
`define ST_PULL_UP_BIT 3
`define ST_PULL_DOWN_BIT 4
`define ST_DRIVE_BIT 5

`endif

// File: logic/io_cell_pkg.sv
package io_cell_pkg;

  // ==========================================================================
  // Pad treatment
  typedef enum logic [1:0]
  {
    PAD_PULL_UP = 2'h0,
    PAD_PULL_DOWN = 2'h1,
    PAD_DRIVEN = 2'h2,
    PAD_EXTERNAL = 2'h3
  } pad_mode_type;

  // ==========================================================================
  // Configuration word, bit 7 down to bit 0
  typedef struct packed
  {
    pad_mode_type pad_mode;
    logic ce_to_out;
    logic ce_to_in;
    logic out_clk_invert;
    logic in_clk_invert;
    logic out_init_set;
    logic in_init_set;
  } cell_config_type;

  // ==========================================================================
  // Pad drive controls
  typedef struct packed
  {
    logic drive;
    logic oe;
    logic pull_up;
    logic pull_down;
  } pad_control_type;

  // ==========================================================================
  // Whole state of the cell
  typedef struct packed
  {
    cell_config_type cfg;
    logic in_q;
    logic out_q;
    logic in_clk_prev;
    logic out_clk_prev;
    logic ack;
    logic [31:0] rdata;
  } cell_state_type;

endpackage

// File: logic/io_cell_register_control.sv
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "io_cell_defines.svh"

// Notes on behaviour
// R1: Global set/reset forces both registers' init values
// R2: Each register's set/clear chosen separately
// R3: No user set/reset besides global net
// R4: One choice serves start-up and global reset
// R5: Input and output registers have separate clocks
// R6: Each register clock may be inverted
// R7: Every cell takes its own clock inputs
// R8: Both registers share one clock enable
// R9: Enable routed to input, output or both
// R10: Clock enable active high, never inverted
// R11: Unused pads default to pull-up
// R12: Pad may pull down, drive, or float
// R13: Disabled register holds; enabled register loads
module io_cell_register_control
  import io_cell_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic global_set_reset_net_i,
  input wire logic input_register_clock_i,
  input wire logic output_register_clock_i,
  input wire logic shared_clock_enable_i,
  input wire logic out_data_i,
  input wire logic pad_in_i,
  output logic in_q_o,
  output pad_control_type pad_o
);

  // ==========================================================================
  // Helpers

  // Clock pins are sampled on clk_i; an edge is seen at the first clk_i edge that samples the new level
  function automatic logic active_edge(input logic prev, input logic cur,
                                       input logic invert);
    if (invert)
    begin
      // Inverted clock: capture on the falling edge
      active_edge = prev & ~cur;
    end
    else
    begin
      active_edge = ~prev & cur;
    end
  endfunction

  // An enable left unrouted to either register counts as always high
  function automatic logic enable_for(input logic routed,
                                      input logic any_routed,
                                      input logic ce);
    if (!any_routed)
    begin
      // Unrouted enable leaves both registers free-running
      enable_for = 1'b1;
    end
    else if (routed)
    begin
      enable_for = ce;
    end
    else
    begin
      // Routed only to the other register
      enable_for = 1'b1;
    end
  endfunction

  // Read-back word of the configuration, upper lanes zero
  function automatic logic [31:0] config_word(input cell_config_type cfg);
    config_word = {24'h000000, cfg};
  endfunction

  // Status word: both registers, the pad level and its treatment
  function automatic logic [31:0] status_word(input logic in_q,
                                              input logic out_q,
                                              input logic level,
                                              input pad_control_type pc);
    logic [31:0] w;
    w = '0;
    // Register values
    w[`ST_IN_Q_BIT] = in_q;
    w[`ST_OUT_Q_BIT] = out_q;
    // Pad level as seen now, then how the pad is treated
    w[`ST_PAD_LEVEL_BIT] = level;
    w[`ST_PULL_UP_BIT] = pc.pull_up;
    w[`ST_PULL_DOWN_BIT] = pc.pull_down;
    w[`ST_DRIVE_BIT] = pc.oe;
    status_word = w;
  endfunction

  // Address match for one register offset
  function automatic logic is_offset(input logic [7:0] adr,
                                     input logic [7:0] offset);
    is_offset = (adr == offset);
  endfunction

  // One I/O register: loads on an enabled active edge, else holds
  function automatic logic register_next(input logic q,
                                         input logic fire,
                                         input logic enable,
                                         input logic d);
    if (fire && enable)
    begin
      register_next = d;
    end
    else
    begin
      register_next = q;
    end
  endfunction

  // Pad treatment for one mode; the cell only drives in driven mode
  function automatic pad_control_type pad_for_mode(input pad_mode_type mode,
                                                   input logic out_q);
    pad_control_type pc;
    pc = '0;
    case (mode)
      // R11: default pull-up
      PAD_PULL_UP:
      begin
        pc.drive = 1'b0;
        pc.oe = 1'b0;
        pc.pull_up = 1'b1;
        pc.pull_down = 1'b0;
      end
      // R12: pull-down, driven or external
      PAD_PULL_DOWN:
      begin
        pc.drive = 1'b0;
        pc.oe = 1'b0;
        pc.pull_up = 1'b0;
        pc.pull_down = 1'b1;
      end
      // Pulls stay off while driving, so no current fights the driver
      PAD_DRIVEN:
      begin
        pc.drive = out_q;
        pc.oe = 1'b1;
        pc.pull_up = 1'b0;
        pc.pull_down = 1'b0;
      end
      // Left to a far source; nothing holds the level here
      PAD_EXTERNAL:
      begin
        pc.drive = 1'b0;
        pc.oe = 1'b0;
        pc.pull_up = 1'b0;
        pc.pull_down = 1'b0;
      end
      default:
      begin
        pc.drive = 1'b0;
        pc.oe = 1'b0;
        pc.pull_up = 1'b1;
        pc.pull_down = 1'b0;
      end
    endcase
    pad_for_mode = pc;
  endfunction

  // ==========================================================================
  // State

  cell_state_type s;
  cell_state_type next_s;
  cell_state_type reset_s;
  logic req;
  logic take;
  logic any_routed;
  logic in_edge;
  logic out_edge;
  logic startup;
  pad_control_type pad;

  // Decoded strobes of the current cycle
  logic in_enable;
  logic out_enable;
  logic read_start;
  logic write_hit;
  logic sel_cfg;
  logic sel_ctrl;
  logic sel_status;
  logic init_load;

  always_comb
  begin
    reset_s = '0;
    reset_s.cfg = cell_config_type'(`CFG_RESET);
    reset_s.rdata = `RDATA_RESET;
    // Pin history starts low: a pin high at release gives an edge
    reset_s.in_q = 1'b0;
    reset_s.out_q = 1'b0;
    reset_s.in_clk_prev = 1'b0;
    reset_s.out_clk_prev = 1'b0;
    reset_s.ack = 1'b0;
  end

  // ==========================================================================
  // Pad treatment
  always_comb
  begin
    pad = pad_for_mode(s.cfg.pad_mode, s.out_q);
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    // ======================================================================
    // Defaults, overridden below in order of priority
    next_s = s;
    req = cyc_i & stb_i;
    take = req & s.ack;
    startup = 1'b0;
    any_routed = s.cfg.ce_to_in | s.cfg.ce_to_out;

    // ======================================================================
    // Clock pins
    // Pin pulses shorter than one clock period may be missed
    // R5: separate clock inputs per register
    // R7: clock pins belong to this cell only
    next_s.in_clk_prev = input_register_clock_i;
    next_s.out_clk_prev = output_register_clock_i;
    // R6: per-register clock inversion
    in_edge = active_edge(s.in_clk_prev, input_register_clock_i,
                          s.cfg.in_clk_invert);
    out_edge = active_edge(s.out_clk_prev, output_register_clock_i,
                           s.cfg.out_clk_invert);

    // ======================================================================
    // Clock enable routing
    // R8: one enable shared by both
    // R9: enable routed per configuration
    // R10: enable used high-true only
    in_enable = enable_for(s.cfg.ce_to_in, any_routed,
                           shared_clock_enable_i);
    out_enable = enable_for(s.cfg.ce_to_out, any_routed,
                            shared_clock_enable_i);

    // ======================================================================
    // Register loads
    // R13: hold unless enabled on active edge
    next_s.in_q = register_next(s.in_q, in_edge, in_enable, pad_in_i);
    next_s.out_q = register_next(s.out_q, out_edge, out_enable, out_data_i);

    // ======================================================================
    // Bus decode
    // A request is captured once; ack then blocks a second capture
    read_start = req & ~s.ack;
    sel_cfg = is_offset(adr_i, `CFG_OFFSET);
    sel_ctrl = is_offset(adr_i, `CTRL_OFFSET);
    sel_status = is_offset(adr_i, `STATUS_OFFSET);
    // Only byte lane 0 carries configuration and control bits
    write_hit = take & we_i & sel_i[0];

    // ======================================================================
    // Bus answer
    // Ack one cycle after the request, high for one cycle
    next_s.ack = read_start;

    // ======================================================================
    // Read data, captured as the request is first seen
    if (read_start)
    begin
      if (sel_cfg)
      begin
        next_s.rdata = config_word(s.cfg);
      end
      else if (sel_status)
      begin
        next_s.rdata = status_word(s.in_q, s.out_q, pad_in_i, pad);
      end
      else
      begin
        // Unmapped and write-only offsets read as zero
        next_s.rdata = '0;
      end
    end

    // ======================================================================
    // Register writes, landing on the edge that samples ack
    if (write_hit && sel_cfg)
    begin
      next_s.cfg = cell_config_type'(dat_i[7:0]);
    end
    // The start-up strobe is a one-cycle pulse, never stored
    if (write_hit && sel_ctrl)
    begin
      startup = dat_i[`CTRL_STARTUP_BIT];
    end

    // ======================================================================
    // Global set/reset and start-up
    // R1: global net forces init values
    // R2: separate set/clear per register
    // R3: only global net or start-up set/reset
    // R4: same choice for start-up and global
    // Uses the stored choice, so a write in the same cycle waits
    // The global net wins over any clock edge in the same cycle
    init_load = global_set_reset_net_i | startup;
    if (init_load)
    begin
      next_s.in_q = s.cfg.in_init_set;
      next_s.out_q = s.cfg.out_init_set;
    end
  end

  // ==========================================================================
  // Registers
  // Synchronous reset only; the global net acts through next state
  // so that both share one path into the register bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= reset_s;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  // Data outputs come straight from flops
  // Pad controls follow the stored mode with no extra delay
  assign dat_o = s.rdata;
  assign ack_o = s.ack;
  assign in_q_o = s.in_q;
  assign pad_o = pad;

endmodule

// File: sim/io_cell_pad_model.sv
`timescale 1ns/100ps
module io_cell_pad_model
  import io_cell_pkg::*;
(
  input wire pad_control_type pad_i,
  input wire logic ext_i,
  output logic level_o
);
  // Cell drive beats the pulls; a floating pad follows the far source
  assign level_o = pad_i.oe ? pad_i.drive :
    pad_i.pull_up | (!pad_i.pull_down & ext_i);
endmodule

// File: sim/io_cell_register_control_chk.sv
`timescale 1ns/100ps
module io_cell_chk
  import io_cell_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic global_set_reset_net_i,
  input wire logic input_register_clock_i,
  input wire logic shared_clock_enable_i,
  input wire logic pad_in_i,
  input wire logic in_q_o,
  input wire pad_control_type pad_o
);
  cell_config_type c;
  wire k = input_register_clock_i;
  wire idle = !cyc_i && !global_set_reset_net_i;
  // Shadow config, taken at the acked write edge like the cell
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      c <= '0;
    else if (cyc_i && we_i && ack_o && adr_i == 8'h00)
      c <= dat_i[7:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence calm_s;
    !k ##1 !k && idle;
  endsequence
  sequence rise_s;
    !k ##1 k && idle && !c.in_clk_invert &&
    (!c.ce_to_in || shared_clock_enable_i);
  endsequence
  chk_global_in: assert property (global_set_reset_net_i
    |=> in_q_o == $past(c.in_init_set)) else $error("global in");
  chk_global_out: assert property (global_set_reset_net_i
    && c.pad_mode == 2 |=> pad_o.drive == $past(c.out_init_set))
    else $error("global out");
  chk_pad_up: assert property (c.pad_mode == 0 |-> pad_o == 4'h2)
    else $error("pull-up");
  chk_pad_down: assert property (c.pad_mode == 1 |-> pad_o == 4'h1)
    else $error("pull-down");
  chk_pad_open: assert property (c.pad_mode == 3 |-> pad_o == 4'h0)
    else $error("float");
  chk_in_hold: assert property (c.ce_to_in && idle
    && !shared_clock_enable_i |=> $stable(in_q_o)) else $error("hold");
  chk_no_edge: assert property (calm_s |=> $stable(in_q_o))
    else $error("stray load");
  chk_in_load: assert property (rise_s
    |=> in_q_o == $past(pad_in_i)) else $error("load");
endmodule
bind io_cell_register_control io_cell_chk io_cell_chk_i (.*);

// File: sim/io_cell_register_control_test.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  n_mismatch++; $display("Error %0t: mismatch", $time); end end
module io_cell_register_control_test import io_cell_pkg::*;;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, gnet = 0, ick = 0, ock = 0;
  logic ce = 0, ext = 0, od = 0, ack_o, in_q_o, lvl;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, dat_o, rd;
  logic [1:0] v;
  pad_control_type pad_o;
  int n_mismatch = 0, n_checks = 0, seed = 52;
  always #20 clk_i = ~clk_i;
  io_cell_register_control io_cell_register_control_i (.clk_i, .rst_i,
    .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o, .ack_o, .global_set_reset_net_i(gnet),
    .input_register_clock_i(ick), .output_register_clock_i(ock),
    .shared_clock_enable_i(ce), .out_data_i(od), .pad_in_i(lvl),
    .in_q_o, .pad_o);
  io_cell_pad_model io_cell_pad_model_i (.pad_i(pad_o), .ext_i(ext),
    .level_o(lvl));
  task automatic final_report;
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge clk_i) {cyc, we, adr, dat, sel} <= {w | 1'b1, w, a, 24'h0, d,
      4'h1};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc <= 0;
  endtask
  task automatic glob;
    @(posedge clk_i) gnet <= 1;
    @(posedge clk_i) gnet <= 0;
    @(posedge clk_i);
  endtask
  // Driven pads expect the output register set
  function automatic logic [3:0] exp_pad(logic [1:0] m);
    return m == 0 ? 4'h2 : m == 1 ? 4'h1 : m == 2 ? 4'hc : 4'h0;
  endfunction
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h08, 0);
    `CHK(rd[5:0], 6'h0c)
    wb(0, 8'h40, 0);
    `CHK(rd, 0)
    repeat (4)
    begin
      v = 2'($random(seed));
      wb(1, 0, {6'h0, v});
      glob;
      wb(0, 8'h08, 0);
      `CHK(rd[1:0], v)
      wb(1, 0, {6'h0, ~v});
      wb(1, 8'h04, 1);
      wb(0, 8'h08, 0);
      `CHK(rd[1:0], ~v)
    end
    for (int m = 0; m < 4; m++)
    begin
      ext <= 1'($random(seed));
      wb(1, 0, {m[1:0], 6'h02});
      glob;
      `CHK(pad_o, exp_pad(m[1:0]))
      wb(0, 8'h08, 0);
      `CHK(rd[2], m == 3 ? ext : m != 1)
    end
    // Bit 0 inverts, bits 2:1 route the enable, bit 3 is its level
    for (int i = 0; i < 16; i++)
    begin
      wb(1, 0, {2'h0, i[2:1], {2{i[0]}}, 2'h0});
      glob;
      {ce, ick, od} <= {i[3], 1'b1, 1'($random(seed))};
      repeat (2) @(posedge clk_i);
      `CHK(in_q_o, (!i[1] | i[3]) & !i[0])
      wb(0, 8'h08, 0);
      `CHK(rd[1], 1'b0)
      {ick, ock} <= 2'b01;
      repeat (2) @(posedge clk_i);
      ock <= 0;
      repeat (2) @(posedge clk_i);
      wb(0, 8'h08, 0);
      `CHK(rd[1:0], {(!i[2] | i[3]) & od, !i[1] | i[3]})
    end
    final_report;
  end
  initial
  begin
    repeat (4000) @(posedge clk_i);
    n_mismatch++;
    final_report;
  end
endmodule
